/* File: common/panel_pkg.sv */
// constants shared by the front-panel indicator block
`default_nettype none
package panel_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int BLINK_HALF_MS = 250;
  localparam int ACT_HOLD_MS = 100;
  localparam int BLINK_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int ACT_CYC = ACT_HOLD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int NPORTS = 2;
  // register byte offsets
  localparam logic [7:0] OFS_STATE = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_MASK = 8'h0C;
  // fields of the state register
  localparam int ST_DIAG_PASS = 0;
  localparam int ST_INIT_DONE = 1;
  localparam int ST_PROC_OK = 2;
  localparam int ST_RUN_MODE = 3;
  localparam int ST_HALT = 4;
  localparam int ST_BOOT_WAIT = 5;
  localparam int ST_SCAN_EN = 6;
  localparam int ST_FORCE = 7;
  localparam int ST_FATAL = 8;
  localparam int ST_BAT_FAIL = 9;
  localparam int ST_BAT_LOW = 10;
  localparam int ST_SMART_BAT = 11;
  localparam int ST_CTL_W = 12;
  localparam int ST_ERR_LSB = 16;
  localparam int ERR_W = 8;
  localparam logic [ST_CTL_W-1:0] CTL_RESET = 12'h000;
  localparam logic [ERR_W-1:0] ERR_RESET = 8'h00;
  // lamp positions, also the low byte of the status register
  localparam int L_HEALTH = 0;
  localparam int L_RUN = 1;
  localparam int L_SCAN = 2;
  localparam int L_FORCE = 3;
  localparam int L_BAT = 4;
  localparam int L_SYS = 5;
  localparam int L_SER1 = 6;
  localparam int L_SER2 = 7;
  localparam int STS_UPG_VALID = 8;
  localparam int STS_UPG_PORT = 9;
  localparam int STS_STEP_LSB = 10;
  // interrupt bits
  localparam int IRQ_FATAL = 0;
  localparam int IRQ_BATTERY = 1;
  localparam int IRQ_HALT = 2;
  localparam int IRQ_SER1 = 3;
  localparam int IRQ_SER2 = 4;
  localparam int IRQ_W = 5;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;
endpackage : panel_pkg
`default_nettype wire

/* File: common/led_time_if.sv */
// shared blink timebase and per-port activity hold between timebase and lamp logic
`default_nettype none
interface led_time_if #(parameter int NP = 2);
  logic blink;
  logic tick;
  logic [NP-1:0] act_pulse;
  logic [NP-1:0] act_busy;
  modport src (output blink, output tick, output act_busy, input act_pulse);
  modport dst (input blink, input tick, input act_busy, output act_pulse);
endinterface : led_time_if
`default_nettype wire

/* File: logic/led_timebase.sv */
// blink divider and serial activity hold timers
`default_nettype none
module led_timebase import panel_pkg::*; #(
  parameter int BLINK_C = BLINK_CYC,
  parameter int ACT_C = ACT_CYC,
  parameter int NP = NPORTS
) (
  input wire logic clk,       // system clock
  input wire logic rst_n,     // synchronised reset, active low
  led_time_if.src tb          // timebase outputs
);
  localparam int CW = (BLINK_C < 2) ? 1 : $clog2(BLINK_C);
  localparam int AW = (ACT_C < 2) ? 1 : $clog2(ACT_C + 1);

  generate
    if (BLINK_C < 2 || ACT_C < 1 || NP < 1) begin : g_bad
      $error("led_timebase: unusable timing parameters");
    end
  endgenerate

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic blink;
    logic tick;
    logic [NP-1:0][AW-1:0] hold;
  } tb_s;

  tb_s st;
  tb_s next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    // one divider serves every lamp so that lamps blinking together stay in phase
    if (st.cnt == CW'(BLINK_C - 1)) begin // R13
      next_st.cnt = '0;
      next_st.tick = 1'b1;
      next_st.blink = ~st.blink; // R13
    end else begin
      next_st.cnt = st.cnt + CW'(1);
    end
    for (int p = 0; p < NP; p++) begin
      if (tb.act_pulse[p]) begin
        next_st.hold[p] = AW'(ACT_C); // R11
      end else if (st.hold[p] != '0) begin
        next_st.hold[p] = st.hold[p] - AW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tb.blink = st.blink;
  assign tb.tick = st.tick;
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      tb.act_busy[p] = (st.hold[p] != '0);
    end
  end

  property p_blink_on_tick;
    @(posedge clk) disable iff (!rst_n)
    (st.blink != $past(st.blink)) |-> st.tick;
  endproperty
  a_blink_on_tick: assert property (p_blink_on_tick) // R13
    else $error("blink changed without a divider tick");
endmodule : led_timebase
`default_nettype wire

/* File: logic/front_panel.sv */
// front-panel status lamp controller with AHB-Lite register slave
// Summary of operation
// R1 - health lamp is steady on only when diagnostics passed, init is done and the processor is ok.
// R2 - on a processor problem health goes off and run/output lamps flash an error code.
// R3 - in halt the health lamp blinks and every other lamp is off; the code gives boot wait priority, so halt with boot wait shows the R4 pattern.
// R4 - in boot wait health, run and output-scan lamps blink together.
// R5 - run lamp is on in run mode and off in stop mode.
// R6 - output-scan lamp is on while output scan is enabled, off otherwise.
// R7 - force lamp is on while any bit override is active.
// R8 - battery lamp is off when normal, blinks when low, is steady when failed or absent.
// R9 - the low state is shown only when a smart battery reports it.
// R10 - system fault lamp is steady on after a fatal fault; the code holds it off during boot wait.
// R11 - each serial port lamp blinks while its own port has traffic.
// R12 - two independent serial ports, either may carry a firmware upgrade.
// R13 - all blinking comes from one shared timebase.
`default_nettype none
module front_panel import panel_pkg::*; #(
  parameter int BLINK_C = BLINK_CYC,
  parameter int ACT_C = ACT_CYC
) (
  input wire logic CLK_I,               // 20 MHz system clock
  input wire logic ARST_N_I,            // asynchronous reset, active low
  input wire logic HSEL_I,              // ahb slave select
  input wire logic [31:0] HADDR_I,      // ahb address
  input wire logic [1:0] HTRANS_I,      // ahb transfer type
  input wire logic HWRITE_I,            // ahb write
  input wire logic [2:0] HSIZE_I,       // ahb size
  input wire logic [31:0] HWDATA_I,     // ahb write data
  input wire logic HREADY_I,            // ahb bus ready
  output logic [31:0] HRDATA_O,         // ahb read data
  output logic HREADYOUT_O,             // ahb slave ready
  output logic HRESP_O,                 // ahb response, always okay
  input wire logic SER_ONE_ACT_I,       // serial_port_one traffic pin
  input wire logic SER_TWO_ACT_I,       // serial_port_two traffic pin
  output logic HEALTH_LED_O,            // health lamp
  output logic RUN_LED_O,               // run lamp
  output logic OUTPUT_SCAN_LED_O,       // output_scan_indicator lamp
  output logic FORCE_LED_O,             // force lamp
  output logic BATTERY_LED_O,           // battery lamp
  output logic SYS_FAULT_LED_O,         // system fault lamp
  output logic SER_ONE_LED_O,           // serial_port_one activity lamp
  output logic SER_TWO_LED_O,           // serial_port_two activity lamp
  output logic IRQ_O                    // interrupt, active high level
);
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  typedef struct packed {
    logic [ST_CTL_W-1:0] ctl;
    logic [ERR_W-1:0] err_code;
    logic [IRQ_W-1:0] int_stat;
    logic [IRQ_W-1:0] int_mask;
    logic [1:0] act_meta;
    logic [1:0] act_sync;
    logic [1:0] act_prev;
    logic [7:0] led;
    logic [31:0] rdata;
    logic wr_pend;
    logic [7:0] waddr;
    logic [2:0] step;
    logic upg_valid;
    logic upg_port;
    logic fatal_prev;
    logic bat_prev;
    logic halt_prev;
  } top_s;

  top_s st;
  top_s next_st;

  led_time_if #(.NP(NPORTS)) tb ();

  led_timebase #(.BLINK_C(BLINK_C), .ACT_C(ACT_C), .NP(NPORTS)) u_tb (
    .clk(CLK_I),
    .rst_n(rst_n),
    .tb(tb.src)
  );

  logic [1:0] act_pulse;
  logic normal;
  logic bat_degraded;
  logic addr_ok;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  // traffic edges seen by both ports independently
  assign act_pulse = st.act_sync & ~st.act_prev; // R11 R12
  assign tb.act_pulse = act_pulse;
  assign normal = st.ctl[ST_DIAG_PASS] & st.ctl[ST_INIT_DONE] & st.ctl[ST_PROC_OK]; // R1
  // a plain battery cannot report low, so only a smart one reaches the blink state
  assign bat_degraded = st.ctl[ST_BAT_FAIL] | (st.ctl[ST_SMART_BAT] & st.ctl[ST_BAT_LOW]); // R9
  assign addr_ok = HSEL_I & HTRANS_I[1] & HREADY_I;

  function automatic logic [31:0] read_reg(input top_s s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      OFS_STATE: begin
        v[ST_CTL_W-1:0] = s.ctl;
        v[ST_ERR_LSB +: ERR_W] = s.err_code;
      end
      OFS_STATUS: begin
        v[7:0] = s.led;
        v[STS_UPG_VALID] = s.upg_valid;
        v[STS_UPG_PORT] = s.upg_port;
        v[STS_STEP_LSB +: 3] = s.step;
      end
      OFS_INT_STAT: v[IRQ_W-1:0] = s.int_stat;
      OFS_INT_MASK: v[IRQ_W-1:0] = s.int_mask;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : read_reg

  always_comb begin
    next_st = st;
    irq_clr = '0;
    irq_set = '0;
    next_st.act_meta = {SER_TWO_ACT_I, SER_ONE_ACT_I};
    next_st.act_sync = st.act_meta;
    next_st.act_prev = st.act_sync;
    // bus data phase
    next_st.wr_pend = 1'b0;
    if (st.wr_pend) begin
      case (st.waddr)
        OFS_STATE: begin
          next_st.ctl = HWDATA_I[ST_CTL_W-1:0];
          next_st.err_code = HWDATA_I[ST_ERR_LSB +: ERR_W];
        end
        OFS_INT_STAT: irq_clr = HWDATA_I[IRQ_W-1:0];
        OFS_INT_MASK: next_st.int_mask = HWDATA_I[IRQ_W-1:0];
        default: next_st.ctl = st.ctl;
      endcase
    end
    // bus address phase; reads see the value before a write in its data phase
    if (addr_ok) begin
      next_st.wr_pend = HWRITE_I;
      next_st.waddr = {HADDR_I[7:2], 2'b00};
      if (!HWRITE_I) begin
        next_st.rdata = read_reg(st, {HADDR_I[7:2], 2'b00});
      end
    end
    // events, a new event beats a clear in the same cycle
    next_st.fatal_prev = st.ctl[ST_FATAL];
    next_st.bat_prev = bat_degraded;
    next_st.halt_prev = st.ctl[ST_HALT];
    irq_set[IRQ_FATAL] = st.ctl[ST_FATAL] & ~st.fatal_prev;
    irq_set[IRQ_BATTERY] = bat_degraded & ~st.bat_prev;
    irq_set[IRQ_HALT] = st.ctl[ST_HALT] & ~st.halt_prev;
    irq_set[IRQ_SER1] = act_pulse[0];
    irq_set[IRQ_SER2] = act_pulse[1];
    next_st.int_stat = (st.int_stat & ~irq_clr) | irq_set;
    // firmware source: first port to show traffic during boot wait
    if (!st.ctl[ST_BOOT_WAIT]) begin
      next_st.upg_valid = 1'b0;
    end else if (!st.upg_valid && (act_pulse != 2'b00)) begin // R12
      next_st.upg_valid = 1'b1;
      next_st.upg_port = ~act_pulse[0];
    end
    // error code walks one bit per blink period
    if (normal || st.ctl[ST_HALT] || st.ctl[ST_BOOT_WAIT]) begin
      next_st.step = 3'h0;
    end else if (tb.tick && tb.blink) begin
      next_st.step = st.step + 3'h1;
    end
    // lamps
    next_st.led[L_FORCE] = st.ctl[ST_FORCE]; // R7
    if (st.ctl[ST_BAT_FAIL]) begin
      next_st.led[L_BAT] = 1'b1; // R8
    end else if (st.ctl[ST_SMART_BAT] && st.ctl[ST_BAT_LOW]) begin
      next_st.led[L_BAT] = tb.blink; // R8 R9
    end else begin
      next_st.led[L_BAT] = 1'b0; // R8
    end
    next_st.led[L_SYS] = st.ctl[ST_FATAL]; // R10
    next_st.led[L_SER1] = tb.act_busy[0] & tb.blink; // R11
    next_st.led[L_SER2] = tb.act_busy[1] & tb.blink; // R11
    if (st.ctl[ST_BOOT_WAIT]) begin
      next_st.led[L_HEALTH] = tb.blink; // R4
      next_st.led[L_RUN] = tb.blink; // R4
      next_st.led[L_SCAN] = tb.blink; // R4
      next_st.led[L_SYS] = 1'b0;
    end else if (st.ctl[ST_HALT]) begin
      next_st.led = '0; // R3
      next_st.led[L_HEALTH] = tb.blink; // R3
    end else if (!normal) begin
      next_st.led[L_HEALTH] = 1'b0; // R2
      next_st.led[L_RUN] = tb.blink & st.err_code[st.step]; // R2
      next_st.led[L_SCAN] = tb.blink & (st.step == 3'h0); // R2
    end else begin
      next_st.led[L_HEALTH] = 1'b1; // R1
      next_st.led[L_RUN] = st.ctl[ST_RUN_MODE]; // R5
      next_st.led[L_SCAN] = st.ctl[ST_SCAN_EN]; // R6
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.ctl <= CTL_RESET;
      st.err_code <= ERR_RESET;
      st.int_stat <= IRQ_RESET;
      st.int_mask <= IRQ_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign HRDATA_O = st.rdata;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign HEALTH_LED_O = st.led[L_HEALTH];
  assign RUN_LED_O = st.led[L_RUN];
  assign OUTPUT_SCAN_LED_O = st.led[L_SCAN];
  assign FORCE_LED_O = st.led[L_FORCE];
  assign BATTERY_LED_O = st.led[L_BAT];
  assign SYS_FAULT_LED_O = st.led[L_SYS];
  assign SER_ONE_LED_O = st.led[L_SER1];
  assign SER_TWO_LED_O = st.led[L_SER2];
  assign IRQ_O = |(st.int_stat & st.int_mask);

  logic mode_plain;
  assign mode_plain = ~st.ctl[ST_BOOT_WAIT] & ~st.ctl[ST_HALT];

  property p_health_on;
    @(posedge CLK_I) disable iff (!rst_n)
    (mode_plain && normal) |=> HEALTH_LED_O;
  endproperty
  a_health_on: assert property (p_health_on) // R1
    else $error("health lamp not steady in normal operation");

  property p_problem;
    @(posedge CLK_I) disable iff (!rst_n)
    (mode_plain && !normal) |=> !HEALTH_LED_O && (OUTPUT_SCAN_LED_O == ($past(tb.blink)
      && ($past(st.step) == 3'h0)));
  endproperty
  a_problem: assert property (p_problem) // R2
    else $error("problem pattern wrong");

  property p_halt;
    @(posedge CLK_I) disable iff (!rst_n)
    (st.ctl[ST_HALT] && !st.ctl[ST_BOOT_WAIT]) |=> (HEALTH_LED_O == $past(tb.blink))
      && ({RUN_LED_O, OUTPUT_SCAN_LED_O, FORCE_LED_O, BATTERY_LED_O, SYS_FAULT_LED_O,
      SER_ONE_LED_O, SER_TWO_LED_O} == 7'h00);
  endproperty
  a_halt: assert property (p_halt) // R3
    else $error("halt lamps wrong");

  property p_boot;
    @(posedge CLK_I) disable iff (!rst_n)
    st.ctl[ST_BOOT_WAIT] |=> (HEALTH_LED_O == $past(tb.blink)) && (RUN_LED_O == HEALTH_LED_O)
      && (OUTPUT_SCAN_LED_O == HEALTH_LED_O);
  endproperty
  a_boot: assert property (p_boot) // R4
    else $error("boot lamps not in unison");

  property p_run_scan;
    @(posedge CLK_I) disable iff (!rst_n)
    (mode_plain && normal) |=> (RUN_LED_O == $past(st.ctl[ST_RUN_MODE]))
      && (OUTPUT_SCAN_LED_O == $past(st.ctl[ST_SCAN_EN]));
  endproperty
  a_run_scan: assert property (p_run_scan) // R5 R6
    else $error("run or output scan lamp wrong");

  property p_force;
    @(posedge CLK_I) disable iff (!rst_n)
    !st.ctl[ST_HALT] |=> FORCE_LED_O == $past(st.ctl[ST_FORCE]);
  endproperty
  a_force: assert property (p_force) // R7
    else $error("force lamp wrong");

  property p_battery;
    @(posedge CLK_I) disable iff (!rst_n)
    !st.ctl[ST_HALT] |=> BATTERY_LED_O == ($past(st.ctl[ST_BAT_FAIL]) ||
      ($past(st.ctl[ST_SMART_BAT]) && $past(st.ctl[ST_BAT_LOW]) && $past(tb.blink)));
  endproperty
  a_battery: assert property (p_battery) // R8 R9
    else $error("battery lamp wrong");

  property p_fault;
    @(posedge CLK_I) disable iff (!rst_n)
    (mode_plain && st.ctl[ST_FATAL]) |=> SYS_FAULT_LED_O;
  endproperty
  a_fault: assert property (p_fault) // R10
    else $error("system fault lamp not on");

  property p_activity;
    @(posedge CLK_I) disable iff (!rst_n)
    (mode_plain && act_pulse[0]) |-> ##1 tb.act_busy[0];
  endproperty
  a_activity: assert property (p_activity) // R11
    else $error("port one activity not held");

  property p_irq_set_wins;
    @(posedge CLK_I) disable iff (!rst_n)
    act_pulse[1] |=> st.int_stat[IRQ_SER2];
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins) // R12
    else $error("port two event lost");

  c_boot: cover property (@(posedge CLK_I) disable iff (!rst_n)
    st.ctl[ST_BOOT_WAIT] ##1 HEALTH_LED_O);
  c_upgrade: cover property (@(posedge CLK_I) disable iff (!rst_n) st.upg_valid && st.upg_port);
  c_bat_low: cover property (@(posedge CLK_I) disable iff (!rst_n)
    BATTERY_LED_O && !st.ctl[ST_BAT_FAIL]);
  c_irq: cover property (@(posedge CLK_I) disable iff (!rst_n) IRQ_O);
endmodule : front_panel
`default_nettype wire

/* File: sim/lamp_panel.sv */
// behavioural lamp bank on the far side: counts lit cycles and switch-on edges
`default_nettype none
module lamp_panel (
  input wire logic clk_i,         // system clock
  input wire logic clr_i,         // restart the counts
  input wire logic [7:0] lamp_i,  // lamp drive, high = lit
  output var int on_o [8],        // cycles each lamp was lit
  output var int rise_o [8]       // times each lamp switched on
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] prev = 8'h00;
  // a lamp only sees levels, so a blink shows as repeated switch-on edges
  always @(posedge clk_i) begin
    for (int i = 0; i < 8; i++) begin
      on_o[i] <= clr_i ? 0 : on_o[i] + int'(lamp_i[i] === 1'b1);
      rise_o[i] <= clr_i ? 0 : rise_o[i] + int'(lamp_i[i] === 1'b1 && prev[i] !== 1'b1);
    end
    prev <= lamp_i;
  end
endmodule : lamp_panel
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the front-panel lamp controller
`default_nettype none
module tb_top import panel_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BC = 8;
  localparam int AC = 20;
  localparam int LIMIT = 20000;
  typedef struct packed {logic [31:0] st; logic [7:0] lamp;} row_s;
  // steady cases: state word and the lamp byte it must give
  localparam row_s ROWS [8] = '{
    '{32'h0000_0007, 8'h01}, '{32'h0000_000F, 8'h03}, '{32'h0000_0047, 8'h05},
    '{32'h0000_0087, 8'h09}, '{32'h0000_0207, 8'h11}, '{32'h0000_0A07, 8'h11},
    '{32'h0000_0407, 8'h01}, '{32'h0000_0107, 8'h21}};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic ser1 = 1'b0;
  logic ser2 = 1'b0;
  logic clr = 1'b0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic irq;
  wire [7:0] lamps;
  logic [31:0] rd;
  int on_c [8];
  int rise_c [8];
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int bad;

  always #25 clk = ~clk;

  front_panel #(.BLINK_C(BC), .ACT_C(AC)) u_front_panel (
    .CLK_I(clk), .ARST_N_I(arst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .SER_ONE_ACT_I(ser1), .SER_TWO_ACT_I(ser2),
    .HEALTH_LED_O(lamps[L_HEALTH]), .RUN_LED_O(lamps[L_RUN]),
    .OUTPUT_SCAN_LED_O(lamps[L_SCAN]), .FORCE_LED_O(lamps[L_FORCE]),
    .BATTERY_LED_O(lamps[L_BAT]), .SYS_FAULT_LED_O(lamps[L_SYS]),
    .SER_ONE_LED_O(lamps[L_SER1]), .SER_TWO_LED_O(lamps[L_SER2]), .IRQ_O(irq));

  lamp_panel u_lamp_panel (.clk_i(clk), .clr_i(clr), .lamp_i(lamps), .on_o(on_c),
    .rise_o(rise_c));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // the master never assumes a latency; the cycle ceiling ends a hang
  task automatic wait_ready();
    do @(posedge clk); while (hready !== 1'b1);
  endtask : wait_ready

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    chk("hresp_okay", {31'h0000_0000, hresp}, 32'h0000_0000);
  endtask : ahb

  task automatic wr_state(input logic [31:0] v);
    ahb(1'b1, OFS_STATE, v);
    repeat (3) @(posedge clk);
  endtask : wr_state

  task automatic sample(input int n);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : sample

  task automatic pulse(input logic two);
    if (two) begin
      ser2 <= 1'b1;
    end else begin
      ser1 <= 1'b1;
    end
    repeat (2) @(posedge clk);
    ser1 <= 1'b0;
    ser2 <= 1'b0;
    sample(30);
  endtask : pulse

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    chk("reset_outputs", {23'h00_0000, irq, lamps}, 32'h0000_0000);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (ROWS[i]) begin
      wr_state(ROWS[i].st);
      chk("row_lamps", {24'h00_0000, lamps}, {24'h00_0000, ROWS[i].lamp});
      ahb(1'b0, OFS_STATUS, 32'h0000_0000);
      chk("row_status", {24'h00_0000, rd[7:0]}, {24'h00_0000, ROWS[i].lamp});
    end
    // halt with every cause but boot wait raised: only the health lamp may light
    wr_state(32'h0000_0FDF);
    sample(6 * BC);
    chk("halt_health_blink", 32'(rise_c[L_HEALTH] > 1), 32'h1);
    bad = on_c[1] + on_c[2] + on_c[3] + on_c[4] + on_c[5] + on_c[6] + on_c[7];
    chk("halt_others_off", 32'(bad), 32'h0);
    wr_state(32'h0000_0020);
    sample(1);
    bad = 0;
    repeat (6 * BC) begin
      @(posedge clk);
      if (lamps[2:0] !== 3'b000 && lamps[2:0] !== 3'b111) bad++;
    end
    chk("boot_unison", 32'(bad), 32'h0);
    chk("boot_blink", 32'(rise_c[L_HEALTH] > 1), 32'h1);
    wr_state(32'h0000_000B);
    sample(6 * BC);
    chk("problem_health_off", 32'(on_c[L_HEALTH]), 32'h0);
    chk("problem_run_code", 32'(on_c[L_RUN]), 32'h0);
    // error code 01: run flashes only in step 0, so it must match the output scan lamp
    wr_state(32'h0001_000B);
    sample(16 * BC);
    chk("problem_code_run", 32'(on_c[L_RUN] > 0), 32'h1);
    chk("problem_code_scan", 32'(on_c[L_SCAN]), 32'(on_c[L_RUN]));
    wr_state(32'h0000_0C07);
    sample(6 * BC);
    chk("bat_low_blink", 32'(rise_c[L_BAT] > 1 && on_c[L_BAT] < 6 * BC), 32'h1);
    // interrupt raised by port one traffic, masked, then cleared
    wr_state(32'h0000_0007);
    ahb(1'b0, OFS_INT_STAT, 32'h0000_0000);
    chk("int_events", rd, 32'h0000_0007);
    ahb(1'b1, OFS_INT_STAT, 32'h0000_001F);
    ahb(1'b1, OFS_INT_MASK, 32'h0000_0008);
    pulse(1'b0);
    chk("ser1_blink", 32'(rise_c[L_SER1] > 0), 32'h1);
    chk("ser2_quiet", 32'(on_c[L_SER2]), 32'h0);
    chk("irq_raised", {31'h0, irq}, 32'h1);
    ahb(1'b0, OFS_INT_STAT, 32'h0000_0000);
    chk("int_stat", rd, 32'h0000_0008);
    ahb(1'b1, OFS_INT_MASK, 32'h0000_0000);
    @(posedge clk);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    ahb(1'b1, OFS_INT_MASK, 32'h0000_0008);
    ahb(1'b1, OFS_INT_STAT, 32'h0000_0008);
    @(posedge clk);
    chk("irq_cleared", {31'h0, irq}, 32'h0);
    // upgrade port latches the first port seen while waiting in boot
    wr_state(32'h0000_0020);
    pulse(1'b1);
    chk("ser2_blink", 32'(rise_c[L_SER2] > 0), 32'h1);
    chk("ser1_quiet", 32'(on_c[L_SER1]), 32'h0);
    pulse(1'b0);
    ahb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("upgrade_port", {30'h0, rd[STS_UPG_PORT:STS_UPG_VALID]}, 32'h3);
    ahb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped_read", rd, 32'h0000_0000);
    // reset in mid-run drops lamps and interrupt at once, registers come back cleared
    wr_state(32'h0000_0387);
    chk("pre_reset_lamps", {24'h00_0000, lamps}, 32'h0000_0039);
    arst_n <= 1'b0;
    @(posedge clk);
    chk("mid_reset_outputs", {23'h00_0000, irq, lamps}, 32'h0000_0000);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    ahb(1'b0, OFS_STATE, 32'h0000_0000);
    chk("mid_reset_state", rd, 32'h0000_0000);
    ahb(1'b0, OFS_INT_MASK, 32'h0000_0000);
    chk("mid_reset_mask", rd, 32'h0000_0000);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
